// ===== lfps_engine.sv
// Function
// - every transmitted cycle has a period between 20 ns and 100 ns.
// - a burst is continuous cycles for the burst time, one per repeat interval, idle between.
// - the burst length carries the message and the receiver decodes by measured duration.
// - polling bursts last 0.6 to 1.4 us and repeat every 6 to 14 us.
// - ping bursts last 40 to 200 ns with at least two cycles and repeat every 160 to 240 ms.
// - warm reset is one continuous burst of 80 to 120 ms.
// - warm reset and all exit and wakeup signals are single bursts never re-sent.
// - no burst ends before its minimum duration.
// - a U1 exit burst lasts at least 300 ns and at most 900 ns, or 2 ms if the partner is in U2.
// - U2 or loopback exit and U3 wakeup last at least 80 us, ending by 2 ms or 10 ms.
// - a response to U2 exit or U3 wakeup also carries at least 80 us of signalling.
// - ping is declared from one burst's duration alone, ignoring the repeat interval.
// - a port watching for U1 exit tells a ping apart from a U1 exit burst.
// - a burst still active at 300 ns is U1 exit and starts the U1 exit answer burst.
// - a burst ending before 300 ns is a ping and gets no answer.
`timescale 1ns/1ps
`default_nettype none

module lfps_engine #(
  parameter int CNT_W = 25,
  parameter int PING_REPEAT_CYC = lfps_pkg::PING_REPEAT_NS / lfps_pkg::CLK_PERIOD_NS,
  parameter int WARM_BURST_CYC = lfps_pkg::WARM_BURST_NS / lfps_pkg::CLK_PERIOD_NS,
  parameter int U1_MAX_U2_CYC = lfps_pkg::U1_MAX_U2_NS / lfps_pkg::CLK_PERIOD_NS,
  parameter int UX_MIN_CYC = (lfps_pkg::UX_MIN_NS + lfps_pkg::CLK_PERIOD_NS - 1)
                             / lfps_pkg::CLK_PERIOD_NS,
  parameter int U2_MAX_CYC = lfps_pkg::U2_MAX_NS / lfps_pkg::CLK_PERIOD_NS,
  parameter int U3_MAX_CYC = lfps_pkg::U3_MAX_NS / lfps_pkg::CLK_PERIOD_NS,
  parameter int RX_WARM_CYC = lfps_pkg::RX_WARM_MIN_NS / lfps_pkg::CLK_PERIOD_NS
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire lfps_pkg::txCmd_s txCmd,
  input wire logic u1Watch,
  input wire logic rxIdle,
  output logic txLfps,
  output logic txActive,
  output logic txBusy,
  output logic txDone,
  output lfps_pkg::rxEvt_s rxEvt
);

  // elaboration checks on counts the logic must hold
  localparam int PERIOD_CHK = 2 * lfps_pkg::HALF_CYC * lfps_pkg::CLK_PERIOD_NS;
  if (PERIOD_CHK < lfps_pkg::LFPS_PERIOD_MIN_NS || PERIOD_CHK > lfps_pkg::LFPS_PERIOD_MAX_NS)
    $error("cycle period out of range");
  if (lfps_pkg::HALF_CYC < 1)
    $error("half period below one clock");
  // 2 ** CNT_W must stay a positive int, so the width stops at 30
  if (CNT_W < 4 || CNT_W > 30 || PING_REPEAT_CYC >= (2 ** CNT_W) || RX_WARM_CYC >= (2 ** CNT_W)
      || WARM_BURST_CYC >= (2 ** CNT_W) || U1_MAX_U2_CYC >= (2 ** CNT_W)
      || U2_MAX_CYC >= (2 ** CNT_W) || U3_MAX_CYC >= (2 ** CNT_W))
    $error("counter width too small for counts");
  if (UX_MIN_CYC > U2_MAX_CYC || UX_MIN_CYC > U3_MAX_CYC || U1_MAX_U2_CYC < lfps_pkg::U1_MIN_CYC)
    $error("burst limits inconsistent");

  typedef logic [CNT_W-1:0] cnt_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_BURST = 3'b010,
    S_GAP = 3'b100
  } txState_e;

  // least burst length per message
  function automatic cnt_t burstMin(input lfps_pkg::msg_e m);
    unique case (m)
      lfps_pkg::MSG_POLLING: burstMin = cnt_t'(lfps_pkg::POLL_BURST_CYC);
      lfps_pkg::MSG_PING: burstMin = cnt_t'(lfps_pkg::PING_BURST_CYC);
      lfps_pkg::MSG_WARM_RESET: burstMin = cnt_t'(WARM_BURST_CYC);
      lfps_pkg::MSG_U1_EXIT: burstMin = cnt_t'(lfps_pkg::U1_MIN_CYC);
      lfps_pkg::MSG_U2_EXIT, lfps_pkg::MSG_U3_WAKE: burstMin = cnt_t'(UX_MIN_CYC);
      default: burstMin = cnt_t'(lfps_pkg::POLL_BURST_CYC);
    endcase
  endfunction : burstMin

  // longest burst length per message
  function automatic cnt_t burstMax(input lfps_pkg::msg_e m, input logic pU2);
    unique case (m)
      lfps_pkg::MSG_U1_EXIT:
        burstMax = pU2 ? cnt_t'(U1_MAX_U2_CYC) : cnt_t'(lfps_pkg::U1_MAX_U1_CYC);
      lfps_pkg::MSG_U2_EXIT: burstMax = cnt_t'(U2_MAX_CYC);
      lfps_pkg::MSG_U3_WAKE: burstMax = cnt_t'(U3_MAX_CYC);
      default: burstMax = burstMin(m);
    endcase
  endfunction : burstMax

  // transmit state
  txState_e state_reg, state_next;
  lfps_pkg::msg_e msg_reg;
  logic partnerU2_reg;
  cnt_t txCnt_reg, txCnt_next;
  logic [7:0] halfCnt_reg, halfCnt_next;
  logic txLfps_next;

  // receive state
  logic idleMeta_reg, idleSync_reg, prevActive_reg;
  cnt_t rxCnt_reg, rxCnt_next;

  // receive duration measurement decode
  wire rxActive = ~idleSync_reg;
  wire rxRise = rxActive & ~prevActive_reg;
  wire rxFall = ~rxActive & prevActive_reg;
  wire rxCntMax = &rxCnt_reg;
  wire pingHit = rxFall & (rxCnt_reg < cnt_t'(lfps_pkg::RX_U1_THRESH_CYC));
  wire u1Hit = rxActive & prevActive_reg & u1Watch
               & (rxCnt_reg == cnt_t'(lfps_pkg::RX_U1_THRESH_CYC));
  wire pollHit = rxFall & (rxCnt_reg >= cnt_t'(lfps_pkg::RX_POLL_MIN_CYC))
                 & (rxCnt_reg <= cnt_t'(lfps_pkg::RX_POLL_MAX_CYC));
  wire warmHit = rxActive & prevActive_reg & (rxCnt_reg == cnt_t'(RX_WARM_CYC));

  // transmit start and burst limits
  wire txIdle = (state_reg == S_IDLE);
  wire startGo = txIdle & (txCmd.go | u1Hit);
  wire lfps_pkg::msg_e startMsg = txCmd.go ? txCmd.msg : lfps_pkg::MSG_U1_EXIT;
  wire repeating = (msg_reg == lfps_pkg::MSG_POLLING) | (msg_reg == lfps_pkg::MSG_PING);
  wire cnt_t curMin = burstMin(msg_reg);
  wire cnt_t curMax = burstMax(msg_reg, partnerU2_reg);
  wire cnt_t curRep = (msg_reg == lfps_pkg::MSG_PING) ? cnt_t'(PING_REPEAT_CYC)
                                                      : cnt_t'(lfps_pkg::POLL_REPEAT_CYC);
  wire cnt_t txCntInc = txCnt_reg + cnt_t'(1);
  wire burstEnd = (txCntInc >= curMin) & (~txCmd.hold | (txCntInc >= curMax));
  wire repeatEnd = txCntInc >= curRep;
  wire halfEnd = halfCnt_reg == 8'(lfps_pkg::HALF_CYC - 1);

  // transmit sequencer: burst, then stop, or for polling and ping an idle gap, then repeat or stop
  always_comb begin
    state_next = state_reg;
    txCnt_next = txCntInc;
    halfCnt_next = halfEnd ? 8'h00 : halfCnt_reg + 8'h01;
    txLfps_next = halfEnd ? ~txLfps : txLfps;
    unique case (state_reg)
      S_IDLE: begin
        txCnt_next = '0;
        halfCnt_next = 8'h00;
        txLfps_next = 1'b0;
        if (startGo) begin
          state_next = S_BURST;
          txLfps_next = 1'b1;
        end
      end
      S_BURST: begin
        if (burstEnd) begin
          txLfps_next = 1'b0;
          state_next = repeating ? S_GAP : S_IDLE;
        end
      end
      S_GAP: begin
        txLfps_next = 1'b0;
        halfCnt_next = 8'h00;
        if (repeatEnd) begin
          txCnt_next = '0;
          if (txCmd.hold) begin
            state_next = S_BURST;
            txLfps_next = 1'b1;
          end else begin
            state_next = S_IDLE;
          end
        end
      end
      default: state_next = S_IDLE;
    endcase
  end

  // receive duration counter, restarted at each break of idle
  always_comb begin
    rxCnt_next = rxCnt_reg;
    if (rxRise) begin
      rxCnt_next = cnt_t'(1);
    end else if (rxActive && !rxCntMax) begin
      rxCnt_next = rxCnt_reg + cnt_t'(1);
    end
  end

  // transmit registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= S_IDLE;
      txCnt_reg <= '0;
      halfCnt_reg <= 8'h00;
      txLfps <= 1'b0;
      txActive <= 1'b0;
      txBusy <= 1'b0;
      txDone <= 1'b0;
      msg_reg <= lfps_pkg::MSG_POLLING;
      partnerU2_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      txCnt_reg <= txCnt_next;
      halfCnt_reg <= halfCnt_next;
      txLfps <= txLfps_next;
      txActive <= (state_next == S_BURST);
      txBusy <= (state_next != S_IDLE);
      txDone <= ~txIdle & (state_next == S_IDLE);
      if (startGo) begin
        msg_reg <= startMsg;
        partnerU2_reg <= txCmd.partnerU2;
      end
    end
  end

  // idle detector synchroniser and classification pulses
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      idleMeta_reg <= 1'b1;
      idleSync_reg <= 1'b1;
      prevActive_reg <= 1'b0;
      rxCnt_reg <= '0;
      rxEvt <= '0;
    end else begin
      idleMeta_reg <= rxIdle;
      idleSync_reg <= idleMeta_reg;
      prevActive_reg <= rxActive;
      rxCnt_reg <= rxCnt_next;
      rxEvt.ping <= pingHit;
      rxEvt.u1Exit <= u1Hit;
      rxEvt.polling <= pollHit;
      rxEvt.warmReset <= warmHit;
    end
  end

endmodule : lfps_engine

`default_nettype wire

// ===== lfps_engine_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module lfps_engine_asserts #(
  parameter int WARM_BURST_CYC = 10000000,
  parameter int U1_MAX_U2_CYC = 200000,
  parameter int U2_MAX_CYC = 200000,
  parameter int U3_MAX_CYC = 1000000,
  parameter int PING_REPEAT_CYC = 20000000,
  parameter int RX_WARM_CYC = 8000000
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire lfps_pkg::txCmd_s txCmd,
  input wire logic u1Watch,
  input wire logic rxIdle,
  input wire logic txLfps,
  input wire logic txActive,
  input wire logic txBusy,
  input wire logic txDone,
  input wire lfps_pkg::rxEvt_s rxEvt
);
  // longest burst any message may reach
  localparam int LEN_A = (WARM_BURST_CYC > U3_MAX_CYC) ? WARM_BURST_CYC : U3_MAX_CYC;
  localparam int LEN_B = (U1_MAX_U2_CYC > U2_MAX_CYC) ? U1_MAX_U2_CYC : U2_MAX_CYC;
  localparam int LEN_MAX = (LEN_A > LEN_B) ? LEN_A : LEN_B;
  logic [31:0] runLen;
  logic [31:0] curLow;
  logic [31:0] lastLow;
  logic [31:0] sinceRise;
  logic prevAct;
  // cycles since the last start of an own burst
  always_ff @(posedge ref_clk) begin
    prevAct <= rst ? 1'b0 : txActive;
    sinceRise <= (rst || (txActive && !prevAct)) ? 32'h1 : sinceRise + 32'h1;
  end
  // lengths of the own burst, the live idle break and the last finished break
  always_ff @(posedge ref_clk) begin
    runLen <= (rst || !txActive) ? 32'h0 : runLen + 32'h1;
    curLow <= (rst || rxIdle) ? 32'h0 : curLow + 32'h1;
    lastLow <= rst ? 32'h0 : ((rxIdle && curLow != 32'h0) ? curLow : lastLow);
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_period; $rose(txLfps) |=> txLfps ##1 !txLfps; endproperty
  a_period: assert property (p_period) else $error("tx half cycle wrong");
  property p_idle; !txActive |-> !txLfps; endproperty
  a_idle: assert property (p_idle) else $error("lane toggles in idle");
  property p_start; txCmd.go && !txBusy |=> txActive && txBusy; endproperty
  a_start: assert property (p_start) else $error("burst did not start");
  property p_len; $fell(txActive) |-> runLen >= 8 && runLen <= LEN_MAX; endproperty
  a_len: assert property (p_len) else $error("burst length out of range");
  property p_pulse; rxEvt != 4'h0 |=> rxEvt == 4'h0; endproperty
  a_pulse: assert property (p_pulse) else $error("event not one cycle");
  property p_ping; rxEvt.ping |-> rxIdle && lastLow <= 31; endproperty
  a_ping: assert property (p_ping) else $error("ping on long burst");
  property p_u1; rxEvt.u1Exit |-> u1Watch && curLow >= 28 && curLow <= 34; endproperty
  a_u1: assert property (p_u1) else $error("u1 exit at wrong time");
  property p_ans; rxEvt.u1Exit && !$past(txBusy) |-> ##[0:2] txActive; endproperty
  a_ans: assert property (p_ans) else $error("no u1 exit answer");
  property p_poll; rxEvt.polling |-> rxIdle && lastLow >= 58 && lastLow <= 142; endproperty
  a_poll: assert property (p_poll) else $error("polling misjudged");
  property p_warm; rxEvt.warmReset |-> !rxIdle && curLow >= RX_WARM_CYC - 2
    && curLow <= RX_WARM_CYC + 6; endproperty
  a_warm: assert property (p_warm) else $error("warm reset misjudged");
  property p_done; txDone |-> !txBusy && $past(txBusy); endproperty
  a_done: assert property (p_done) else $error("done without end");
  property p_rep; $rose(txActive) && $past(txBusy)
    |-> sinceRise == PING_REPEAT_CYC || sinceRise == lfps_pkg::POLL_REPEAT_CYC; endproperty
  a_rep: assert property (p_rep) else $error("repeat interval wrong");
endmodule : lfps_engine_asserts
bind lfps_engine lfps_engine_asserts #(.WARM_BURST_CYC(WARM_BURST_CYC),
  .U1_MAX_U2_CYC(U1_MAX_U2_CYC), .U2_MAX_CYC(U2_MAX_CYC), .U3_MAX_CYC(U3_MAX_CYC),
  .PING_REPEAT_CYC(PING_REPEAT_CYC),
  .RX_WARM_CYC(RX_WARM_CYC)) chk (.ref_clk(ref_clk), .rst(rst), .txCmd(txCmd),
  .u1Watch(u1Watch), .rxIdle(rxIdle), .txLfps(txLfps), .txActive(txActive),
  .txBusy(txBusy), .txDone(txDone), .rxEvt(rxEvt));
`default_nettype wire

// ===== lfps_pkg.sv
`default_nettype none

package lfps_pkg;

  // local clock
  localparam int CLK_PERIOD_NS = 10;

  // transmitted cycle period and its half in clocks
  localparam int LFPS_PERIOD_NS = 40;
  localparam int LFPS_PERIOD_MIN_NS = 20;
  localparam int LFPS_PERIOD_MAX_NS = 100;
  localparam int HALF_CYC = LFPS_PERIOD_NS / (2 * CLK_PERIOD_NS);

  // transmit burst and repeat times
  localparam int POLL_BURST_NS = 1000;
  localparam int POLL_REPEAT_NS = 10000;
  localparam int PING_BURST_NS = 120;
  localparam int PING_REPEAT_NS = 200000000;
  localparam int WARM_BURST_NS = 100000000;
  localparam int U1_MIN_NS = 300;
  localparam int U1_MAX_U1_NS = 900;
  localparam int U1_MAX_U2_NS = 2000000;
  localparam int UX_MIN_NS = 80000;
  localparam int U2_MAX_NS = 2000000;
  localparam int U3_MAX_NS = 10000000;

  // receive classification times
  localparam int RX_U1_THRESH_NS = 300;
  localparam int RX_POLL_MIN_NS = 600;
  localparam int RX_POLL_MAX_NS = 1400;
  localparam int RX_WARM_MIN_NS = 80000000;

  // polling times and the U1 longest time truncate; ping burst, U1 least time and U1 threshold round up
  localparam int POLL_BURST_CYC = POLL_BURST_NS / CLK_PERIOD_NS;
  localparam int POLL_REPEAT_CYC = POLL_REPEAT_NS / CLK_PERIOD_NS;
  localparam int PING_BURST_CYC = (PING_BURST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int U1_MIN_CYC = (U1_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int U1_MAX_U1_CYC = U1_MAX_U1_NS / CLK_PERIOD_NS;
  localparam int RX_U1_THRESH_CYC = (RX_U1_THRESH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RX_POLL_MIN_CYC = RX_POLL_MIN_NS / CLK_PERIOD_NS;
  localparam int RX_POLL_MAX_CYC = RX_POLL_MAX_NS / CLK_PERIOD_NS;

  // message kinds
  typedef enum logic [2:0] {
    MSG_POLLING = 3'h0,
    MSG_PING = 3'h1,
    MSG_WARM_RESET = 3'h2,
    MSG_U1_EXIT = 3'h3,
    MSG_U2_EXIT = 3'h4,
    MSG_U3_WAKE = 3'h5
  } msg_e;

  // transmit request from the link state machine
  typedef struct packed {
    logic go;
    logic hold;
    logic partnerU2;
    msg_e msg;
  } txCmd_s;

  // classification pulses toward the link state machine
  typedef struct packed {
    logic ping;
    logic u1Exit;
    logic polling;
    logic warmReset;
  } rxEvt_s;

endpackage : lfps_pkg

`default_nettype wire

// ===== link_partner.sv
`timescale 1ns/1ps
`default_nettype none
module link_partner (
  input wire logic ref_clk,
  input wire logic fire,
  input wire logic [15:0] len,
  output logic rxIdle
);
  // idle detector level: low for len cycles while the far port bursts, moved on falling edges
  initial begin
    rxIdle = 1'b1;
    forever begin
      @(negedge ref_clk);
      if (fire) begin
        rxIdle <= 1'b0;
        repeat (len) @(negedge ref_clk);
        rxIdle <= 1'b1;
      end
    end
  end
endmodule : link_partner
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic u1Watch = 1'b0;
  logic fire = 1'b0;
  logic [15:0] len = 16'h0;
  lfps_pkg::txCmd_s txCmd = '0;
  logic txLfps, txActive, txBusy, txDone, rxIdle;
  lfps_pkg::rxEvt_s rxEvt;
  logic [19:0] notes[$];
  logic [15:0] txRun = 16'h0;
  int miscompares = 0;
  int n_tests = 0;
  always #5 ref_clk = ~ref_clk;
  // long timers shortened; the 80 us minimum and the 2 ms U1 limit keep their real counts
  lfps_engine #(.PING_REPEAT_CYC(200), .WARM_BURST_CYC(300), .U2_MAX_CYC(8100),
    .U3_MAX_CYC(8200), .RX_WARM_CYC(250)) dut (
    .ref_clk(ref_clk), .rst(rst), .txCmd(txCmd), .u1Watch(u1Watch), .rxIdle(rxIdle),
    .txLfps(txLfps), .txActive(txActive), .txBusy(txBusy), .txDone(txDone), .rxEvt(rxEvt));
  link_partner partner (.ref_clk(ref_clk), .fire(fire), .len(len), .rxIdle(rxIdle));
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic take(input logic [19:0] seen);
    logic [19:0] exp;
    exp = (notes.size() != 0) ? notes.pop_front() : 20'hFFFFF;
    check(seen, exp);
  endtask : take
  task automatic conclude;
    $display("compares=%0d mismatches=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude
  // reps bursts of n cycles, a refused second start mid-burst, then wait for done;
  // hold falls rel cycles into the wait, or only at done when rel is negative
  task automatic send(input logic [2:0] m, input logic h, input logic p2, input logic [15:0] n,
    input int rel, input int reps);
    int k;
    for (int r = 0; r < reps; r++) notes.push_back({4'h2, n});
    txCmd <= {1'b1, h, p2, m};
    @(negedge ref_clk);
    txCmd.go <= 1'b0;
    repeat (4) @(negedge ref_clk);
    txCmd <= {1'b1, h, p2, 3'h2};
    @(negedge ref_clk);
    txCmd.go <= 1'b0;
    k = 0;
    while (txDone !== 1'b1 && k < 10000) begin
      if (k == rel) txCmd.hold <= 1'b0;
      @(negedge ref_clk);
      k++;
    end
    check(20'(txDone), 20'h1);
    txCmd.hold <= 1'b0;
    @(negedge ref_clk);
  endtask : send
  // far port burst of n cycles, with the expected event and answer burst
  task automatic recv(input logic [15:0] n, input logic [3:0] ev, input logic w,
    input logic [15:0] ans);
    if (ev != 4'h0) notes.push_back({4'h1, 12'h0, ev});
    if (ans != 16'h0) notes.push_back({4'h2, ans});
    u1Watch <= w;
    len <= n;
    fire <= 1'b1;
    @(negedge ref_clk);
    fire <= 1'b0;
    repeat (n + 16'h40) @(negedge ref_clk);
  endtask : recv
  // result watcher: events and finished own bursts against the oldest note
  always @(negedge ref_clk) begin
    if (!rst && rxEvt !== 4'h0) take({4'h1, 12'h0, rxEvt});
    if (!rst && txActive === 1'b1) txRun = txRun + 16'h1;
    else if (txRun != 16'h0) begin
      take({4'h2, txRun});
      txRun = 16'h0;
    end
  end
  initial begin
    // all scenarios together take about 36000 cycles
    repeat (50000) @(posedge ref_clk);
    miscompares++;
    conclude();
  end
  initial begin
    void'($urandom(33));
    repeat (4) @(negedge ref_clk);
    rst <= 1'b0;
    send(3'h0, 1'b0, 1'b0, 16'd100, -1, 1);
    send(3'h1, 1'b0, 1'b0, 16'd12, -1, 1);
    // ping kept repeating for two bursts, hold falls in the second gap
    send(3'h1, 1'b1, 1'b0, 16'd12, 250, 2);
    send(3'h2, 1'b1, 1'b0, 16'd300, -1, 1);
    send(3'h3, 1'b0, 1'b0, 16'd30, -1, 1);
    send(3'h3, 1'b1, 1'b0, 16'd90, -1, 1);
    // partner in U2: burst runs past 900 ns until hold falls
    send(3'h3, 1'b1, 1'b1, 16'd150, 144, 1);
    send(3'h4, 1'b0, 1'b0, 16'd8000, -1, 1);
    send(3'h4, 1'b1, 1'b0, 16'd8100, -1, 1);
    send(3'h5, 1'b0, 1'b0, 16'd8000, -1, 1);
    send(3'h5, 1'b1, 1'b0, 16'd8200, -1, 1);
    for (int i = 0; i < 4; i++) begin
      recv(16'(3 + $urandom % 20), 4'h8, 1'b1, 16'h0);
      recv(16'(70 + $urandom % 60), 4'h2, 1'b0, 16'h0);
    end
    recv(16'd40, 4'h4, 1'b1, 16'd30);
    recv(16'd270, 4'h1, 1'b0, 16'h0);
    check(20'(notes.size()), 20'h0);
    conclude();
  end
endmodule : testbench
`default_nettype wire
